/* File: inc/dbsp_pkg.sv */
package dbsp_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int IMP_W = 6;
  localparam int MEM_AW = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W = ADDR_W + DATA_W + LANES;
  localparam int SYNC_W = 7 + ADDR_W + DATA_W + LANES + IMP_W;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_ABSENT_NS = 640;
  localparam int CLK_ABSENT_CYC = CLK_ABSENT_NS / CLK_PERIOD_NS;
  localparam int DLL_LOCK_EDGES = 1024;
  localparam int INIT_CYC = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [IMP_W-1:0] IMP_RESET = 6'h20;
  localparam logic [DATA_W-1:0] Q_RESET = 36'h0;
  localparam logic [SYNC_W-1:0] SYNC_RESET = '1;
  // ----------------------------------------------------------------
  // read output states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_FIRST = 2'h1,
    RD_SECOND = 2'h3
  } dbsp_rd_e;
endpackage

/* File: design/dbsp_fifo.sv */
`timescale 1ns/1ps
module dbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

/* File: design/dbsp_port.sv */
// Notes on behaviour
// - read select low at K rise captures address
// - every command moves two data words
// - base word first, partner word second
// - first word at output edge, second next
// - back-to-back reads stream without gaps
// - output clocks high: time from K edges
// - single clock mode fixed at power up
// - after burst, outputs go high impedance
// - write address captured at K-bar rise
// - write words taken at K and K-bar
// - back-to-back writes accepted every K cycle
// - write data ignored when write deselected
// - active-low lane enables gate nine-bit lanes
// - read and write ports run independently
// - pending reads and writes finish first
// - impedance updates only in idle cycles
// - echo clock pair runs free, data-aligned
// - missing clock resets DLL, 1024 relock
// - DLL pin low disables, high enables
`timescale 1ns/1ps
module dbsp_port (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // clock pins
  input wire logic k_clk_in,
  input wire logic k_clk_n_in,
  input wire logic c_clk_in,
  input wire logic c_clk_n_in,
  input wire logic dll_enable_in,
  // command and write pins
  input wire logic read_sel_n_in,
  input wire logic write_sel_n_in,
  input wire logic [dbsp_pkg::ADDR_W-1:0] shared_address_in,
  input wire logic [dbsp_pkg::DATA_W-1:0] data_in,
  input wire logic [dbsp_pkg::LANES-1:0] lane_write_enable_n_in,
  input wire logic [dbsp_pkg::IMP_W-1:0] impedance_ref_in,
  // read pins
  output logic [dbsp_pkg::DATA_W-1:0] q_out,
  output logic q_oe_n_out,
  output logic echo_clock_out,
  output logic echo_clock_n_out,
  // status
  output logic dll_locked_out,
  output logic [dbsp_pkg::IMP_W-1:0] imp_code_out
);
  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [dbsp_pkg::SYNC_W-1:0] sync1;
  logic [dbsp_pkg::SYNC_W-1:0] sync2;
  logic [3:0] clk_prev;
  logic k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, dll_en_s;
  logic [dbsp_pkg::ADDR_W-1:0] addr_s;
  logic [dbsp_pkg::DATA_W-1:0] data_s;
  logic [dbsp_pkg::LANES-1:0] mask_s;
  logic [dbsp_pkg::IMP_W-1:0] imp_s;
  logic k_rise, kn_rise, c_rise, cn_rise;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= dbsp_pkg::SYNC_RESET;
      sync2 <= dbsp_pkg::SYNC_RESET;
      clk_prev <= 4'hF;
    end else begin
      sync1 <= {k_clk_in, k_clk_n_in, c_clk_in, c_clk_n_in, read_sel_n_in,
                write_sel_n_in, dll_enable_in, shared_address_in, data_in,
                lane_write_enable_n_in, impedance_ref_in};
      sync2 <= sync1;
      clk_prev <= {k_s, kn_s, c_s, cn_s};
    end
  end

  assign {k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, dll_en_s, addr_s, data_s, mask_s, imp_s} = sync2;
  assign k_rise = k_s && !clk_prev[3];
  assign kn_rise = kn_s && !clk_prev[2];
  assign c_rise = c_s && !clk_prev[1];
  assign cn_rise = cn_s && !clk_prev[0];

  // ----------------------------------------------------------------
  // single clock mode strap
  // ----------------------------------------------------------------
  logic [1:0] init_cnt;
  logic init_done;
  logic single_clk;
  logic out_e0, out_e1;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      init_cnt <= 2'h0;
      init_done <= 1'b0;
      single_clk <= 1'b0;
    end else if (!init_done) begin
      if (init_cnt == 2'(dbsp_pkg::INIT_CYC)) begin
        single_clk <= c_s && cn_s;
        init_done <= 1'b1;
      end else begin
        init_cnt <= init_cnt + 2'h1;
      end
    end
  end

  assign out_e0 = single_clk ? kn_rise : cn_rise;
  assign out_e1 = single_clk ? k_rise : c_rise;

  // ----------------------------------------------------------------
  // memory array
  // ----------------------------------------------------------------
  logic [dbsp_pkg::DATA_W-1:0] mem [2**dbsp_pkg::MEM_AW];
  logic drain_valid;
  logic drain_ready;
  logic [dbsp_pkg::ENTRY_W-1:0] drain_entry;
  logic [dbsp_pkg::ADDR_W-1:0] drain_addr;
  logic [dbsp_pkg::DATA_W-1:0] drain_data;
  logic [dbsp_pkg::LANES-1:0] drain_mask;
  logic [dbsp_pkg::DATA_W-1:0] merged;

  assign {drain_addr, drain_data, drain_mask} = drain_entry;

  for (genvar l = 0; l < dbsp_pkg::LANES; l++) begin : g_lane
    assign merged[l*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = drain_mask[l] ?
      mem[drain_addr[dbsp_pkg::MEM_AW-1:0]][l*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] :
      drain_data[l*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W];
  end

  always_ff @(posedge clk_in) begin
    if (drain_valid && drain_ready) begin
      mem[drain_addr[dbsp_pkg::MEM_AW-1:0]] <= merged;
    end
  end

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  logic w_pend;
  logic [dbsp_pkg::DATA_W-1:0] wd0, wd1;
  logic [dbsp_pkg::LANES-1:0] wm0, wm1;
  logic [dbsp_pkg::ADDR_W-1:0] wr_addr;
  logic p0, p1;
  logic push_valid, push_ready;
  logic [dbsp_pkg::ENTRY_W-1:0] push_entry;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_pend <= 1'b0;
      wd0 <= '0;
      wm0 <= '1;
    end else if (k_rise) begin
      w_pend <= !wr_n_s;
      if (!wr_n_s) begin
        wd0 <= data_s;
        wm0 <= mask_s;
      end
    end else if (kn_rise) begin
      w_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_addr <= '0;
      wd1 <= '0;
      wm1 <= '1;
    end else if (kn_rise && w_pend) begin
      wr_addr <= addr_s;
      wd1 <= data_s;
      wm1 <= mask_s;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p0 <= 1'b0;
      p1 <= 1'b0;
    end else if (kn_rise && w_pend) begin
      p0 <= 1'b1;
      p1 <= 1'b1;
    end else if (push_valid && push_ready) begin
      if (p0) begin
        p0 <= 1'b0;
      end else begin
        p1 <= 1'b0;
      end
    end
  end

  assign push_valid = p0 || p1;
  assign push_entry = p0 ? {wr_addr, wd0, wm0} :
    {wr_addr[dbsp_pkg::ADDR_W-1:1], !wr_addr[0], wd1, wm1};

  dbsp_fifo #(
    .WIDTH(dbsp_pkg::ENTRY_W),
    .DEPTH(dbsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_entry),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready),
    .out_data_out(drain_entry)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic rd_pend;
  logic [dbsp_pkg::ADDR_W-1:0] rd_addr;
  logic buf_valid, buf_armed, eligible;
  logic [dbsp_pkg::DATA_W-1:0] buf0, buf1, hold1;
  dbsp_pkg::dbsp_rd_e rd_state;

  assign drain_ready = !rd_pend;
  assign eligible = single_clk ? buf_valid : buf_armed;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else if (k_rise && !rd_n_s) begin
      rd_pend <= 1'b1;
      rd_addr <= addr_s;
    end else begin
      rd_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_valid <= 1'b0;
      buf_armed <= 1'b0;
      buf0 <= '0;
      buf1 <= '0;
    end else if (rd_pend) begin
      buf_valid <= 1'b1;
      buf_armed <= 1'b0;
      buf0 <= mem[rd_addr[dbsp_pkg::MEM_AW-1:0]];
      buf1 <= mem[{rd_addr[dbsp_pkg::MEM_AW-1:1], !rd_addr[0]}];
    end else if (out_e0 && eligible) begin
      buf_valid <= 1'b0;
      buf_armed <= 1'b0;
    end else if (kn_rise && buf_valid) begin
      buf_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_state <= dbsp_pkg::RD_IDLE;
      q_out <= dbsp_pkg::Q_RESET;
      q_oe_n_out <= 1'b1;
      hold1 <= '0;
    end else begin
      unique case (rd_state)
        dbsp_pkg::RD_IDLE: begin
          if (out_e0 && eligible) begin
            q_out <= buf0;
            hold1 <= buf1;
            q_oe_n_out <= 1'b0;
            rd_state <= dbsp_pkg::RD_FIRST;
          end
        end
        dbsp_pkg::RD_FIRST: begin
          if (out_e1) begin
            q_out <= hold1;
            rd_state <= dbsp_pkg::RD_SECOND;
          end
        end
        dbsp_pkg::RD_SECOND: begin
          if (out_e0 && eligible) begin
            q_out <= buf0;
            hold1 <= buf1;
            rd_state <= dbsp_pkg::RD_FIRST;
          end else if (out_e0) begin
            q_oe_n_out <= 1'b1;
            rd_state <= dbsp_pkg::RD_IDLE;
          end
        end
        default: begin
          q_oe_n_out <= 1'b1;
          rd_state <= dbsp_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // echo clocks and impedance
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      echo_clock_out <= 1'b0;
      echo_clock_n_out <= 1'b1;
    end else begin
      echo_clock_out <= single_clk ? k_s : c_s;
      echo_clock_n_out <= single_clk ? kn_s : cn_s;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      imp_code_out <= dbsp_pkg::IMP_RESET;
    end else if (k_rise && rd_state == dbsp_pkg::RD_IDLE && !rd_pend && !buf_valid) begin
      imp_code_out <= imp_s;
    end
  end

  // ----------------------------------------------------------------
  // DLL lock tracking
  // ----------------------------------------------------------------
  logic [6:0] absent_cnt;
  logic [10:0] lock_cnt;
  logic clk_absent;

  assign clk_absent = (absent_cnt == 7'(dbsp_pkg::CLK_ABSENT_CYC));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      absent_cnt <= 7'h0;
    end else if (k_rise) begin
      absent_cnt <= 7'h0;
    end else if (!clk_absent) begin
      absent_cnt <= absent_cnt + 7'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_cnt <= 11'h0;
      dll_locked_out <= 1'b0;
    end else begin
      if (!dll_en_s || clk_absent) begin
        lock_cnt <= 11'h0;
      end else if (k_rise && lock_cnt != 11'(dbsp_pkg::DLL_LOCK_EDGES)) begin
        lock_cnt <= lock_cnt + 11'h1;
      end
      dll_locked_out <= dll_en_s && !clk_absent &&
        (lock_cnt == 11'(dbsp_pkg::DLL_LOCK_EDGES));
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_read_cmd;
    k_rise && !rd_n_s;
  endsequence
  sequence s_first_out;
    out_e0 && eligible;
  endsequence
  sequence s_second_out;
    rd_state == dbsp_pkg::RD_FIRST && out_e1;
  endsequence

  a_read_capture: assert property (s_read_cmd |=> rd_pend && rd_addr == $past(addr_s)
    ##1 buf_valid) else $error("read command not captured");
  a_first_word: assert property (s_first_out |=> !q_oe_n_out && q_out == $past(buf0))
    else $error("first read word wrong");
  a_second_word: assert property (s_second_out |=> q_out == $past(hold1) &&
    rd_state == dbsp_pkg::RD_SECOND) else $error("second read word wrong");
  a_deselect_hiz: assert property (rd_state == dbsp_pkg::RD_SECOND && out_e0 &&
    !eligible |=> q_oe_n_out && rd_state == dbsp_pkg::RD_IDLE) else $error("no high-z");
  a_mode_fixed: assert property (init_done |=> $stable(single_clk))
    else $error("clock mode changed");
  a_write_ignored: assert property (k_rise && wr_n_s |=> !w_pend)
    else $error("deselected write taken");
  a_write_addr: assert property (kn_rise && w_pend |=> wr_addr == $past(addr_s) && p0 && p1)
    else $error("write address not captured");
  a_partner_addr: assert property (!p0 && p1 |-> push_entry[dbsp_pkg::ENTRY_W-1 -:
    dbsp_pkg::ADDR_W] == (wr_addr ^ 20'h1)) else $error("partner address wrong");
  a_imp_idle_only: assert property (imp_code_out != $past(imp_code_out) |->
    $past(rd_state) == dbsp_pkg::RD_IDLE) else $error("impedance moved while driving");
  a_dll_off: assert property (!dll_en_s |=> !dll_locked_out && lock_cnt == 11'h0)
    else $error("DLL not disabled");
  a_clock_absent: assert property (clk_absent && !k_rise |=> lock_cnt == 11'h0)
    else $error("DLL not reset on missing clock");
endmodule

/* File: sim/dbsp_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host controller model
// ----------------------------------------------------------------
module dbsp_host (
  // clock and mode
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic single_in,
  // clock pins
  output logic k_clk_out,
  output logic k_clk_n_out,
  output logic c_clk_out,
  output logic c_clk_n_out,
  // command and write pins
  output logic read_sel_n_out = 1'b1,
  output logic write_sel_n_out = 1'b1,
  output logic [dbsp_pkg::ADDR_W-1:0] shared_address_out = 20'h0,
  output logic [dbsp_pkg::DATA_W-1:0] data_out = 36'h0,
  output logic [dbsp_pkg::LANES-1:0] lane_write_enable_n_out = 4'hF,
  // link phase
  output logic [3:0] phase_out
);
  logic [3:0] cnt = 4'h0;
  logic [3:0] cph;

  // link clock, 16 system clocks a period, stands still when stopped
  always @(posedge clk_in) begin
    if (run_in) begin
      cnt <= cnt + 4'h1;
    end
  end
  assign phase_out = cnt;
  assign cph = cnt - 4'h4;
  assign k_clk_out = ~cnt[3];
  assign k_clk_n_out = cnt[3];
  assign c_clk_out = single_in | ~cph[3];
  assign c_clk_n_out = single_in | cph[3];

  // one link period; unused lines carry noise
  task automatic op(input logic rd, input logic [19:0] ra, input logic wr,
                    input logic [19:0] wa, input logic [35:0] d0, input logic [35:0] d1,
                    input logic [3:0] l0, input logic [3:0] l1);
    do @(posedge clk_in); while (cnt !== 4'hB);
    read_sel_n_out <= ~rd;
    write_sel_n_out <= ~wr;
    shared_address_out <= rd ? ra : 20'($urandom);
    data_out <= wr ? d0 : 36'({$urandom, $urandom});
    lane_write_enable_n_out <= wr ? l0 : 4'($urandom);
    do @(posedge clk_in); while (cnt !== 4'h3);
    read_sel_n_out <= 1'b1;
    write_sel_n_out <= 1'b1;
    shared_address_out <= wr ? wa : 20'($urandom);
    data_out <= wr ? d1 : 36'({$urandom, $urandom});
    lane_write_enable_n_out <= wr ? l1 : 4'($urandom);
  endtask
endmodule

/* File: sim/dbsp_port_tb.sv */
`timescale 1ns/1ps
module dbsp_port_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b1;
  logic single = 1'b0;
  logic dll_en = 1'b0;
  logic [5:0] imp_ref = 6'h0;
  logic mon = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  logic [35:0] exp_q[$];
  logic [35:0] mem[256];
  wire logic k, kn, c, cn, rs_n, ws_n, q_oe_n, echo, echo_n, locked;
  wire logic [19:0] addr;
  wire logic [35:0] din, q;
  wire logic [3:0] lanes_n, phase;
  wire logic [5:0] imp_code;

  always #5 clk = ~clk;

  dbsp_host host_u (.clk_in(clk), .run_in(run), .single_in(single), .k_clk_out(k),
    .k_clk_n_out(kn), .c_clk_out(c), .c_clk_n_out(cn), .read_sel_n_out(rs_n),
    .write_sel_n_out(ws_n), .shared_address_out(addr), .data_out(din),
    .lane_write_enable_n_out(lanes_n), .phase_out(phase));

  dbsp_port dut_u (.clk_in(clk), .rst_n_in(rst_n), .k_clk_in(k), .k_clk_n_in(kn),
    .c_clk_in(c), .c_clk_n_in(cn), .dll_enable_in(dll_en), .read_sel_n_in(rs_n),
    .write_sel_n_in(ws_n), .shared_address_in(addr), .data_in(din),
    .lane_write_enable_n_in(lanes_n), .impedance_ref_in(imp_ref), .q_out(q),
    .q_oe_n_out(q_oe_n), .echo_clock_out(echo), .echo_clock_n_out(echo_n),
    .dll_locked_out(locked), .imp_code_out(imp_code));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  function automatic logic [35:0] rnd();
    rnd = 36'({$urandom, $urandom});
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                        input logic [3:0] en_n);
    merge = old;
    for (int l = 0; l < 4; l++) begin
      if (!en_n[l]) merge[l*9 +: 9] = nw[l*9 +: 9];
    end
  endfunction

  task automatic go(input logic rd, input logic [19:0] ra, input logic wr,
                    input logic [19:0] wa, input logic [3:0] l0, input logic [3:0] l1);
    logic [35:0] d0;
    logic [35:0] d1;
    d0 = rnd();
    d1 = rnd();
    if (rd) begin
      exp_q.push_back(mem[ra[7:0]]);
      exp_q.push_back(mem[ra[7:0] ^ 8'h01]);
    end
    if (wr) begin
      mem[wa[7:0]] = merge(mem[wa[7:0]], d0, l0);
      mem[wa[7:0] ^ 8'h01] = merge(mem[wa[7:0] ^ 8'h01], d1, l1);
    end
    host_u.op(rd, ra, wr, wa, d0, d1, l0, l1);
  endtask

  task automatic idle(input int n);
    repeat (n) go(1'b0, 20'h0, 1'b0, 20'h0, 4'hF, 4'hF);
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // output monitor, just before each output clock rise
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (mon && (phase == (single ? 4'hF : 4'h3) || phase == (single ? 4'h7 : 4'hB))) begin
      chk(36'({echo, echo_n}), 36'({phase[3] ^ single, ~(phase[3] ^ single)}));
      if (q_oe_n === 1'b0) begin
        if (exp_q.size() == 0) chk(36'(q_oe_n), 36'h1);
        else chk(q, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(54));
    repeat (16) @(posedge clk);
    chk(36'({q_oe_n, locked}), 36'h2);
    chk(36'(imp_code), 36'(dbsp_pkg::IMP_RESET));
    rst_n <= 1'b1;
    dll_en <= 1'b1;
    imp_ref <= 6'($urandom);
    repeat (8) @(posedge clk);
    mon <= 1'b1;
    for (int i = 0; i < 8; i++) go(1'b0, 20'h0, 1'b1, 20'(2 * i), 4'h0, 4'h0);
    for (int i = 0; i < 8; i++) begin
      go(1'b0, 20'h0, 1'b1, {12'($urandom), 8'(2 * i + 1)}, 4'($urandom), 4'($urandom));
    end
    idle(4);
    repeat (17600) @(posedge clk);
    chk(36'(locked), 36'h1);
    chk(36'(imp_code), 36'(imp_ref));
    for (int i = 0; i < 8; i++) begin
      go(1'b1, {12'($urandom), 8'(2 * i)}, 1'b1, 20'(8'h40 + 2 * i), 4'h0, 4'h0);
    end
    idle(4);
    chk(36'(q_oe_n), 36'h1);
    for (int i = 0; i < 8; i++) go(1'b1, 20'(8'h41 + 2 * i), 1'b0, 20'h0, 4'hF, 4'hF);
    idle(4);
    run <= 1'b0;
    repeat (80) @(posedge clk);
    chk(36'(locked), 36'h0);
    run <= 1'b1;
    repeat (17600) @(posedge clk);
    chk(36'(locked), 36'h1);
    dll_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk(36'(locked), 36'h0);
    dll_en <= 1'b1;
    mon <= 1'b0;
    single <= 1'b1;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    mon <= 1'b1;
    for (int i = 0; i < 4; i++) go(1'b0, 20'h0, 1'b1, 20'(8'h80 + 2 * i), 4'h0, 4'h0);
    idle(4);
    for (int i = 0; i < 4; i++) go(1'b1, 20'(8'h80 + 2 * i), 1'b0, 20'h0, 4'hF, 4'hF);
    idle(4);
    chk(36'(exp_q.size()), 36'h0);
    finish_test();
  end

  initial begin
    #1000000;
    err_count++;
    finish_test();
  end
endmodule
